//--- fscs_pkg.sv
// Constants, register map and signal groups for the fault rollup block.
// Assumes a single APB clock domain and 32-bit APB data.
package fscs_pkg;

  // ****************************************
  // Register indices (byte address is four times the index)
  // ****************************************
  localparam logic [11:0] FSCS_IDX_ROLLUP = 12'h52d;
  localparam logic [11:0] FSCS_IDX_HOST = 12'h530;
  localparam logic [11:0] FSCS_IDX_CHAIN = 12'h531;
  localparam logic [11:0] FSCS_IDX_CLEAR = 12'h332;
  localparam logic [11:0] FSCS_IDX_MASK_A = 12'h340;
  localparam logic [11:0] FSCS_IDX_MASK_B = 12'h341;
  localparam int FSCS_MIN_ADDR_W = 14;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] FSCS_RST_ROLLUP = 8'h00;
  localparam logic [7:0] FSCS_RST_HOST = 8'h00;
  localparam logic [7:0] FSCS_RST_CHAIN = 8'h00;
  localparam logic [7:0] FSCS_RST_MASK_A = 8'h00;
  localparam logic [7:0] FSCS_RST_MASK_B = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  // Rollup
  localparam int FSCS_RU_PROT = 7;
  localparam int FSCS_RU_COMP = 6;
  localparam int FSCS_RU_FUSE = 5;
  localparam int FSCS_RU_LINK = 4;
  localparam int FSCS_RU_TEMP = 3;
  localparam int FSCS_RU_VOLT = 2;
  localparam int FSCS_RU_SYS = 1;
  localparam int FSCS_RU_SUPPLY = 0;
  // Host port status
  localparam int FSCS_HS_TX_RESP = 4;
  localparam int FSCS_HS_RX_RESP = 3;
  localparam int FSCS_HS_RX_CMD = 2;
  localparam int FSCS_HS_CLEAR = 1;
  localparam int FSCS_HS_STOP = 0;
  localparam logic [7:0] FSCS_HS_USED = 8'h1f;
  // Mask A
  localparam int FSCS_MA_PROT = 7;
  localparam int FSCS_MA_COMP = 6;
  localparam int FSCS_MA_FUSE = 5;
  localparam int FSCS_MA_OT = 4;
  localparam int FSCS_MA_UT = 3;
  localparam int FSCS_MA_OV = 2;
  localparam int FSCS_MA_UV = 1;
  localparam int FSCS_MA_SYS = 0;
  // Mask B
  localparam int FSCS_MB_SUPPLY = 5;
  localparam int FSCS_MB_HOST = 4;
  localparam int FSCS_MB_CHAIN = 3;
  localparam int FSCS_MB_HB = 2;
  localparam int FSCS_MB_TONE = 1;
  localparam int FSCS_MB_CALARM = 0;
  localparam logic [7:0] FSCS_MB_USED = 8'h3f;
  // Clear register
  localparam int FSCS_CL_HOST = 0;
  localparam int FSCS_CL_CHAIN = 1;

  // ****************************************
  // Signal groups
  // ****************************************
  // Levels: any bit set in each neighbouring fault register group
  typedef struct packed {
    logic protector_any;
    logic comparison_any;
    logic fuse_any;
    logic overtemp_any;
    logic undertemp_any;
    logic overvolt_any;
    logic undervolt_any;
    logic system_any;
    logic supply_any;
    logic heartbeat_missing;
    logic heartbeat_too_fast;
    logic alarm_tone_seen;
    logic chain_alarm_seen;
  } fscs_group_s;

  // One-cycle event pulses from the host serial port
  typedef struct packed {
    logic host_tx_resp_err;
    logic host_rx_resp_err;
    logic host_rx_cmd_err;
    logic link_clear_seen;
    logic unexpected_stop_seen;
    logic wake_ping;
    logic wake_pin_seen;
  } fscs_host_evt_s;

  // One-cycle event pulses from the chain ports, in status bit order
  typedef struct packed {
    logic low_port_tx_resp_err;
    logic low_port_rx_resp_err;
    logic low_port_rx_cmd_err;
    logic low_port_bit_err;
    logic high_port_tx_resp_err;
    logic high_port_rx_resp_err;
    logic high_port_rx_cmd_err;
    logic high_port_bit_err;
  } fscs_chain_evt_s;

  typedef enum logic [1:0] {
    FSCS_MODE_SHUTDOWN,
    FSCS_MODE_SLEEP,
    FSCS_MODE_ACTIVE
  } fscs_mode_e;

endpackage

//--- fscs_top.sv
// Fault rollup, alarm pin and communication fault status, behind an APB slave.
// Assumes fault groups arrive as synchronous levels and port faults as
// one-cycle pulses, all on pclk.
`timescale 1ns/1ps
module fscs_top import fscs_pkg::*; #(
  parameter int ADDR_W = 14
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault sources
  input wire fscs_group_s group_in,
  input wire fscs_host_evt_s host_evt,
  input wire fscs_chain_evt_s chain_evt,
  input wire fscs_mode_e mode,
  // Alarm pin and clear strobes to neighbours
  output logic alarm_out_n,
  output logic host_debug_clear,
  output logic chain_debug_clear,
  output logic [7:0] clear_strobe
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (ADDR_W < FSCS_MIN_ADDR_W) begin : g_addr_chk
    $error("ADDR_W too narrow for the register map");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
    logic [ADDR_W-1:0] byte_addr;
    byte_addr = ADDR_W'({idx, 2'b00});
    return a == byte_addr;
  endfunction

  function automatic logic gate(input logic fault, input logic blk);
    return fault & ~blk;
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] rollup_r;
  logic [7:0] rollup_nxt;
  logic [7:0] host_r;
  logic [7:0] host_nxt;
  logic [7:0] chain_r;
  logic [7:0] chain_nxt;
  logic [7:0] mask_a_r;
  logic [7:0] mask_b_r;
  logic [7:0] clear_r;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic alarm_n_r;
  logic host_dbg_r;
  logic chain_dbg_r;

  logic setup_ph;
  logic wr_ph;
  logic mapped;
  logic [7:0] host_set;
  logic [7:0] wbyte;

  assign setup_ph = psel & ~penable;
  assign wr_ph = psel & penable & pready_r & pwrite;
  // Only the low byte carries register data
  assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign mapped = hit(paddr, FSCS_IDX_ROLLUP) | hit(paddr, FSCS_IDX_HOST)
                | hit(paddr, FSCS_IDX_CHAIN) | hit(paddr, FSCS_IDX_CLEAR)
                | hit(paddr, FSCS_IDX_MASK_A) | hit(paddr, FSCS_IDX_MASK_B);

  // ****************************************
  // APB handshake
  // ****************************************
  // Decode in the setup cycle so pready and prdata leave flops with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_ph;
      pslverr_r <= setup_ph & ~mapped;
    end
  end

  always_comb begin
    prdata_nxt = 32'h0000_0000;
    if (hit(paddr, FSCS_IDX_ROLLUP)) begin
      prdata_nxt[7:0] = rollup_r;
    end else if (hit(paddr, FSCS_IDX_HOST)) begin
      prdata_nxt[7:0] = host_r & FSCS_HS_USED;
    end else if (hit(paddr, FSCS_IDX_CHAIN)) begin
      prdata_nxt[7:0] = chain_r;
    end else if (hit(paddr, FSCS_IDX_MASK_A)) begin
      prdata_nxt[7:0] = mask_a_r;
    end else if (hit(paddr, FSCS_IDX_MASK_B)) begin
      prdata_nxt[7:0] = mask_b_r & FSCS_MB_USED;
    end else begin
      prdata_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata_r <= prdata_nxt;
    end
  end

  // ****************************************
  // Mask registers
  // ****************************************
  // Writes to rollup and status words fall through and change nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_a_r <= FSCS_RST_MASK_A;
      mask_b_r <= FSCS_RST_MASK_B;
    end else if (wr_ph && pstrb[0]) begin
      if (hit(paddr, FSCS_IDX_MASK_A)) begin
        mask_a_r <= wbyte;
      end
      if (hit(paddr, FSCS_IDX_MASK_B)) begin
        mask_b_r <= wbyte & FSCS_MB_USED;
      end
    end
  end

  // ****************************************
  // Clear register
  // ****************************************
  // Self-clearing: holds a written 1 for one cycle, reads back 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_r <= 8'h00;
    end else if (wr_ph && hit(paddr, FSCS_IDX_CLEAR)) begin
      clear_r <= wbyte;
    end else begin
      clear_r <= 8'h00;
    end
  end

  // ****************************************
  // Host port status
  // ****************************************
  always_comb begin
    host_set = 8'h00;
    host_set[FSCS_HS_TX_RESP] = host_evt.host_tx_resp_err;
    host_set[FSCS_HS_RX_RESP] = host_evt.host_rx_resp_err;
    host_set[FSCS_HS_RX_CMD] = host_evt.host_rx_cmd_err;
    host_set[FSCS_HS_CLEAR] = host_evt.link_clear_seen
      | (host_evt.wake_ping && (mode == FSCS_MODE_ACTIVE || mode == FSCS_MODE_SLEEP))
      | (host_evt.wake_pin_seen && mode == FSCS_MODE_ACTIVE);
    host_set[FSCS_HS_STOP] = host_evt.unexpected_stop_seen
      | (host_evt.wake_ping && mode == FSCS_MODE_ACTIVE);
  end

  // A fault arriving with the clear survives it
  assign host_nxt = ((clear_r[FSCS_CL_HOST] ? 8'h00 : host_r) | host_set)
                    & FSCS_HS_USED;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_r <= FSCS_RST_HOST;
    end else begin
      host_r <= host_nxt;
    end
  end

  // ****************************************
  // Chain port status
  // ****************************************
  // Bit order of the event struct is the status bit order
  assign chain_nxt = (clear_r[FSCS_CL_CHAIN] ? 8'h00 : chain_r)
                   | chain_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_r <= FSCS_RST_CHAIN;
    end else begin
      chain_r <= chain_nxt;
    end
  end

  // ****************************************
  // Debug detail clears and neighbour strobes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_dbg_r <= 1'b0;
      chain_dbg_r <= 1'b0;
    end else begin
      host_dbg_r <= clear_r[FSCS_CL_HOST];
      chain_dbg_r <= clear_r[FSCS_CL_CHAIN];
    end
  end

  // ****************************************
  // Rollup and alarm pin
  // ****************************************
  // Recomputed every cycle from live levels, so clearing or masking drops it
  always_comb begin
    rollup_nxt = 8'h00;
    rollup_nxt[FSCS_RU_PROT] = gate(group_in.protector_any, mask_a_r[FSCS_MA_PROT]);
    rollup_nxt[FSCS_RU_COMP] = gate(group_in.comparison_any, mask_a_r[FSCS_MA_COMP]);
    rollup_nxt[FSCS_RU_FUSE] = gate(group_in.fuse_any, mask_a_r[FSCS_MA_FUSE]);
    rollup_nxt[FSCS_RU_LINK] = gate(|host_r, mask_b_r[FSCS_MB_HOST])
      | gate(|chain_r, mask_b_r[FSCS_MB_CHAIN])
      | gate(group_in.heartbeat_missing | group_in.heartbeat_too_fast,
             mask_b_r[FSCS_MB_HB])
      | gate(group_in.alarm_tone_seen, mask_b_r[FSCS_MB_TONE])
      | gate(group_in.chain_alarm_seen, mask_b_r[FSCS_MB_CALARM]);
    rollup_nxt[FSCS_RU_TEMP] = gate(group_in.overtemp_any, mask_a_r[FSCS_MA_OT])
      | gate(group_in.undertemp_any, mask_a_r[FSCS_MA_UT]);
    rollup_nxt[FSCS_RU_VOLT] = gate(group_in.overvolt_any, mask_a_r[FSCS_MA_OV])
      | gate(group_in.undervolt_any, mask_a_r[FSCS_MA_UV]);
    rollup_nxt[FSCS_RU_SYS] = gate(group_in.system_any, mask_a_r[FSCS_MA_SYS]);
    rollup_nxt[FSCS_RU_SUPPLY] = gate(group_in.supply_any,
                                      mask_b_r[FSCS_MB_SUPPLY]);
  end

  // Pin and rollup come from the same term so software sees what the pin shows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rollup_r <= FSCS_RST_ROLLUP;
      alarm_n_r <= 1'b1;
    end else begin
      rollup_r <= rollup_nxt;
      alarm_n_r <= ~|rollup_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign alarm_out_n = alarm_n_r;
  assign host_debug_clear = host_dbg_r;
  assign chain_debug_clear = chain_dbg_r;
  assign clear_strobe = clear_r;

endmodule

//--- fscs_top_asserts.sv
// Concurrent checks on the APB answer, alarm pin and clear strobes of the rollup block.
// Assumes it is bound to fscs_top and sees only that module's ports.
`timescale 1ns/1ps
module fscs_top_asserts import fscs_pkg::*; #(
  parameter int ADDR_W = 14
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pin and neighbour strobes
  input wire logic alarm_out_n,
  input wire logic host_debug_clear,
  input wire logic chain_debug_clear,
  input wire logic [7:0] clear_strobe
);
  // ****************************************
  // Decode
  // ****************************************
  localparam logic [ADDR_W-1:0] A_RU = ADDR_W'({FSCS_IDX_ROLLUP, 2'b00});
  localparam logic [ADDR_W-1:0] A_HS = ADDR_W'({FSCS_IDX_HOST, 2'b00});
  localparam logic [ADDR_W-1:0] A_CH = ADDR_W'({FSCS_IDX_CHAIN, 2'b00});
  localparam logic [ADDR_W-1:0] A_CL = ADDR_W'({FSCS_IDX_CLEAR, 2'b00});
  localparam logic [ADDR_W-1:0] A_MA = ADDR_W'({FSCS_IDX_MASK_A, 2'b00});
  localparam logic [ADDR_W-1:0] A_MB = ADDR_W'({FSCS_IDX_MASK_B, 2'b00});
  wire setup = psel && !penable;
  wire mapped = paddr inside {A_RU, A_HS, A_CH, A_CL, A_MA, A_MB};
  wire wr_clr = psel && penable && pready && pwrite && pstrb[0] && (paddr == A_CL);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ****************************************
  // Properties
  // ****************************************
  a_ready_next: assert property (setup |=> pready)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  a_err_unmapped: assert property (setup && !mapped |=> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access flagged as error");
  a_rdata_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_host_rsvd: assert property (pready && !pwrite && paddr == A_HS |-> prdata[7:5] == 3'h0)
    else $error("host status reserved bits set");
  a_alarm_mirror: assert property (setup && !pwrite && paddr == A_RU
    |=> (prdata[7:0] != 8'h00) == !$past(alarm_out_n))
    else $error("rollup read disagrees with alarm pin");
  a_strobe_copy: assert property (wr_clr |=> clear_strobe == $past(pwdata[7:0]))
    else $error("clear strobe differs from written byte");
  a_strobe_idle: assert property (!$past(wr_clr) |-> clear_strobe == 8'h00)
    else $error("clear strobe without a write");
  a_host_clear: assert property (wr_clr && pwdata[0] |-> ##2 host_debug_clear)
    else $error("host debug clear pulse missing");
  a_chain_clear: assert property (wr_clr && pwdata[1] |-> ##2 chain_debug_clear)
    else $error("chain debug clear pulse missing");
endmodule

bind fscs_top fscs_top_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .alarm_out_n, .host_debug_clear, .chain_debug_clear, .clear_strobe
);

//--- fscs_top_tb.sv
// Self-checking bench for the rollup block, driving APB and fault sources directly.
// Assumes the bound checker; masks start unmasked after reset.
`timescale 1ns/1ps
module fscs_top_tb import fscs_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, alarm_out_n, host_debug_clear, chain_debug_clear, e;
  logic [7:0] clear_strobe;
  fscs_group_s group_in = '0;
  fscs_host_evt_s host_evt = '0;
  fscs_chain_evt_s chain_evt = '0;
  fscs_mode_e mode = FSCS_MODE_ACTIVE;
  int num_errors = 0, samples_checked = 0;
  localparam logic [13:0] A_RU = {FSCS_IDX_ROLLUP, 2'b00}, A_HS = {FSCS_IDX_HOST, 2'b00};
  localparam logic [13:0] A_CH = {FSCS_IDX_CHAIN, 2'b00}, A_CL = {FSCS_IDX_CLEAR, 2'b00};
  localparam logic [13:0] A_MA = {FSCS_IDX_MASK_A, 2'b00}, A_MB = {FSCS_IDX_MASK_B, 2'b00};
  // Group level i (from the top bit) -> rollup bit, and its mask bit (8 and up: mask B)
  localparam int RU_BIT[13] = '{7, 6, 5, 3, 3, 2, 2, 1, 0, 4, 4, 4, 4};
  localparam int MK_SEL[13] = '{7, 6, 5, 4, 3, 2, 1, 0, 13, 10, 10, 9, 8};
  // Host event bit, mode (2 active, 1 sleep, 0 shutdown), expected status
  localparam int HE_BIT[10] = '{6, 5, 4, 3, 2, 1, 1, 0, 0, 1};
  localparam int HE_MD[10] = '{2, 2, 2, 2, 2, 1, 2, 2, 1, 0};
  localparam logic [7:0] HE_EXP[10] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h02, 8'h03,
    8'h02, 8'h00, 8'h00};

  fscs_top #(.ADDR_W(14)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .group_in, .host_evt, .chain_evt, .mode, .alarm_out_n, .host_debug_clear,
    .chain_debug_clear, .clear_strobe
  );

  always #50 pclk = ~pclk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(n, 32'h1, "wait states");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(r, exp, what);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_RU, 32'h0, "rollup reset");
    rd(A_HS, 32'h0, "host reset");
    rd(A_CH, 32'h0, "chain reset");
    rd(A_MA, 32'h0, "mask a reset");
    rd(A_MB, 32'h0, "mask b reset");
    apb(1'b0, 14'h0ffc, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    pstrb <= 4'he;
    apb(1'b1, A_MA, 32'hff);
    pstrb <= 4'hf;
    rd(A_MA, 32'h0, "mask strobe off");
    $display("reset and map test done");
    for (int i = 0; i < 13; i++) begin
      group_in <= fscs_group_s'(13'h1 << (12 - i));
      tick(2);
      chk({31'h0, alarm_out_n}, 32'h0, "alarm on");
      rd(A_RU, 32'h1 << RU_BIT[i], "rollup group");
      apb(1'b1, MK_SEL[i] < 8 ? A_MA : A_MB, 32'h1 << (MK_SEL[i] % 8));
      tick(2);
      chk({31'h0, alarm_out_n}, 32'h1, "alarm masked");
      rd(A_RU, 32'h0, "rollup masked");
      group_in <= '0;
      apb(1'b1, MK_SEL[i] < 8 ? A_MA : A_MB, 32'h0);
      tick(2);
      rd(A_RU, 32'h0, "rollup after source gone");
    end
    $display("group rollup test done");
    for (int i = 0; i < 10; i++) begin
      mode <= HE_MD[i] == 2 ? FSCS_MODE_ACTIVE
            : (HE_MD[i] == 1 ? FSCS_MODE_SLEEP : FSCS_MODE_SHUTDOWN);
      @(posedge pclk);
      host_evt <= fscs_host_evt_s'(7'h1 << HE_BIT[i]);
      @(posedge pclk);
      host_evt <= '0;
      tick(3);
      rd(A_HS, {24'h0, HE_EXP[i]}, "host status");
      rd(A_RU, HE_EXP[i] != 8'h00 ? 32'h10 : 32'h0, "rollup link");
      apb(1'b1, A_HS, 32'hff);
      rd(A_HS, {24'h0, HE_EXP[i]}, "host after write");
      apb(1'b1, A_CL, 32'h1);
      tick(3);
      rd(A_HS, 32'h0, "host cleared");
    end
    mode <= FSCS_MODE_ACTIVE;
    $display("host port test done");
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      chain_evt <= fscs_chain_evt_s'(8'h1 << i);
      @(posedge pclk);
      chain_evt <= '0;
      tick(3);
      rd(A_CH, 32'h1 << i, "chain status");
      apb(1'b1, A_RU, 32'hff);
      rd(A_RU, 32'h10, "rollup after write");
      apb(1'b1, A_CL, 32'h2);
      tick(3);
      rd(A_CH, 32'h0, "chain cleared");
    end
    $display("chain port test done");
    print_verdict();
  end
endmodule
